// *** common/css_pkg.sv ***
// constants and types shared by the channel service scheduler
// Overview of operation
// R01: exactly one channel thread granted per slot; slot lasts until thread ends
// R02: under load, slot levels follow a fixed seven-slot sequence, restarted at once
// R03: slot level order is high, middle, high, low, high, middle, high
// R04: per sequence high owns four slots, middle two, low one
// R05: empty high slot goes to middle, else to low
// R06: empty low slot passes to a high requester
// R07: empty middle slot goes high then low; empty low slot with no high goes middle
// R08: with no request anywhere, sequence returns to first slot and idles
// R09: passing is part of the normal grant decision, with no added delay
// R10: slot transition between slots lasts six to ten system clocks
// R11: within one level, lowest channel number is granted first
// R12: a re-requesting served channel waits until its level's others are served
// R13: two bits per channel: pending request flag and granted flag
// R14: request sets request flag; grant sets granted flag and clears request flag
// R15: granted flags clear only as a whole level group, starting a new round
// R16: after serving a level, clear its granted flags if none pending ungranted
// R17: if one is pending ungranted, group stays; it is served next or by passing
// R18: software gives each active channel one of three levels; order uses level and number
// R19: thirty-two channels share one execution engine
// R20: engine takes one grant at a time and reports thread end before next transition
package css_pkg;

  localparam int CHANNEL_COUNT = 32;
  localparam int LEVEL_WIDTH = 2;

  localparam logic [1:0] LEVEL_DISABLED = 2'h0;
  localparam logic [1:0] LEVEL_LOW = 2'h1;
  localparam logic [1:0] LEVEL_MIDDLE = 2'h2;
  localparam logic [1:0] LEVEL_HIGH = 2'h3;

  localparam int SLOT_COUNT = 7;
  localparam int SLOT_INDEX_WIDTH = 3;
  // two bits per slot, slot 0 in the low bits: H M H L H M H
  localparam logic [13:0] SLOT_SEQUENCE = 14'h3B7B;
  localparam logic [2:0] SLOT_FIRST = 3'h0;
  localparam logic [2:0] SLOT_LAST = 3'h6;

  localparam int TRANSITION_MIN_CLOCKS = 6;
  localparam int TRANSITION_MAX_CLOCKS = 10;
  localparam int TRANSITION_COUNT_WIDTH = 4;
  localparam logic [3:0] TRANSITION_CYCLES = 4'(TRANSITION_MIN_CLOCKS);

  typedef enum logic [1:0] {
    CSS_IDLE = 2'b00,
    CSS_TRANSITION = 2'b01,
    CSS_GRANT = 2'b10,
    CSS_EXECUTE = 2'b11
  } css_state_type;

endpackage : css_pkg

// *** common/css_slot_if.sv ***
// slot sequence carrier between scheduler core and slot sequencer
`timescale 1ns/1ps
interface css_slot_if;
  logic advance;
  logic restart;
  logic [1:0] slot_level;
  logic [2:0] slot_index;

  modport sequencer (
    input advance,
    input restart,
    output slot_level,
    output slot_index
  );

  modport scheduler (
    output advance,
    output restart,
    input slot_level,
    input slot_index
  );
endinterface : css_slot_if

// *** hw/css_level_picker.sv ***
// lowest-numbered eligible channel finder for one priority level
`timescale 1ns/1ps
module css_level_picker #(
  parameter int CHANNELS = css_pkg::CHANNEL_COUNT,
  parameter int INDEX_WIDTH = $clog2(CHANNELS)
) (
  input wire logic [CHANNELS-1:0] eligible,
  output logic found,
  output logic [INDEX_WIDTH-1:0] index
);

  always_comb begin
    found = |eligible;
    index = '0;
    // scan downward so the lowest set bit is the last to win
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        index = INDEX_WIDTH'(i); // R11
      end
    end
  end

endmodule : css_level_picker

// *** hw/css_slot_sequencer.sv ***
// seven-slot priority level sequencer
`timescale 1ns/1ps
module css_slot_sequencer (
  input wire logic sys_clk,
  input wire logic reset_n,
  css_slot_if.sequencer slot
);

  logic [2:0] slot_index;
  logic [2:0] next_slot_index;

  always_comb begin
    next_slot_index = slot_index;
    if (slot.restart) begin
      next_slot_index = css_pkg::SLOT_FIRST; // R08
    end else if (slot.advance) begin
      if (slot_index == css_pkg::SLOT_LAST) begin
        next_slot_index = css_pkg::SLOT_FIRST; // R02
      end else begin
        next_slot_index = slot_index + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      slot_index <= css_pkg::SLOT_FIRST;
    end else begin
      slot_index <= next_slot_index;
    end
  end

  // fixed table gives high four, middle two, low one per sequence
  assign slot.slot_level = css_pkg::SLOT_SEQUENCE[{slot_index, 1'b0} +: 2]; // R03 R04
  assign slot.slot_index = slot_index;

endmodule : css_slot_sequencer

// *** hw/css_scheduler.sv ***
// channel service scheduler: request and grant flags, slot sequencing, grant decision
`timescale 1ns/1ps
module css_scheduler #(
  parameter int CHANNELS = css_pkg::CHANNEL_COUNT,
  parameter int INDEX_WIDTH = $clog2(CHANNELS)
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [CHANNELS-1:0] chan_request,
  input wire logic [2*CHANNELS-1:0] chan_priority,
  input wire logic thread_done,
  output logic grant_valid,
  output logic [INDEX_WIDTH-1:0] grant_channel,
  output logic [1:0] grant_level,
  output logic engine_busy,
  output logic scheduler_idle,
  output logic [2:0] slot_index,
  output logic [CHANNELS-1:0] service_request_flag,
  output logic [CHANNELS-1:0] service_granted_flag
);

  css_pkg::css_state_type state;
  css_pkg::css_state_type next_state;
  logic [3:0] trans_count;
  logic [3:0] next_trans_count;
  logic [INDEX_WIDTH-1:0] next_grant_channel;
  logic [1:0] next_grant_level;
  logic [CHANNELS-1:0] next_request_flag;
  logic [CHANNELS-1:0] next_granted_flag;

  logic [CHANNELS-1:0] enabled_mask;
  logic [CHANNELS-1:0] high_mask;
  logic [CHANNELS-1:0] middle_mask;
  logic [CHANNELS-1:0] low_mask;
  logic [CHANNELS-1:0] high_eligible;
  logic [CHANNELS-1:0] middle_eligible;
  logic [CHANNELS-1:0] low_eligible;
  logic high_found;
  logic middle_found;
  logic low_found;
  logic [INDEX_WIDTH-1:0] high_index;
  logic [INDEX_WIDTH-1:0] middle_index;
  logic [INDEX_WIDTH-1:0] low_index;

  logic pick_found;
  logic [INDEX_WIDTH-1:0] pick_channel;
  logic [1:0] pick_level;
  logic [CHANNELS-1:0] pick_onehot;
  logic [CHANNELS-1:0] pick_level_mask;
  logic [CHANNELS-1:0] pick_level_eligible;
  logic decide;
  logic group_clear;
  logic any_eligible;

  css_slot_if slot ();

  css_slot_sequencer u_sequencer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .slot(slot.sequencer)
  );

  // per-channel level decode and eligibility: request pending, not yet granted
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
      logic [1:0] level;
      assign level = chan_priority[2*gi +: 2];
      assign enabled_mask[gi] = (level != css_pkg::LEVEL_DISABLED); // R18
      assign high_mask[gi] = (level == css_pkg::LEVEL_HIGH);
      assign middle_mask[gi] = (level == css_pkg::LEVEL_MIDDLE);
      assign low_mask[gi] = (level == css_pkg::LEVEL_LOW);
      // a served channel is held off by its granted flag until its round ends
      assign high_eligible[gi] = service_request_flag[gi] & ~service_granted_flag[gi]
        & high_mask[gi]; // R12
      assign middle_eligible[gi] = service_request_flag[gi] & ~service_granted_flag[gi]
        & middle_mask[gi]; // R12
      assign low_eligible[gi] = service_request_flag[gi] & ~service_granted_flag[gi]
        & low_mask[gi]; // R12
    end
  endgenerate

  css_level_picker #(
    .CHANNELS(CHANNELS),
    .INDEX_WIDTH(INDEX_WIDTH)
  ) u_pick_high (
    .eligible(high_eligible),
    .found(high_found),
    .index(high_index)
  );

  css_level_picker #(
    .CHANNELS(CHANNELS),
    .INDEX_WIDTH(INDEX_WIDTH)
  ) u_pick_middle (
    .eligible(middle_eligible),
    .found(middle_found),
    .index(middle_index)
  );

  css_level_picker #(
    .CHANNELS(CHANNELS),
    .INDEX_WIDTH(INDEX_WIDTH)
  ) u_pick_low (
    .eligible(low_eligible),
    .found(low_found),
    .index(low_index)
  );

  assign any_eligible = high_found | middle_found | low_found;

  // grant decision with priority passing, purely combinational so passing
  // costs nothing beyond the ordinary transition
  always_comb begin
    pick_found = 1'b1;
    pick_channel = high_index;
    pick_level = css_pkg::LEVEL_HIGH;
    unique case (slot.slot_level)
      css_pkg::LEVEL_HIGH: begin
        if (high_found) begin
          pick_channel = high_index;
          pick_level = css_pkg::LEVEL_HIGH;
        end else if (middle_found) begin
          pick_channel = middle_index; // R05
          pick_level = css_pkg::LEVEL_MIDDLE;
        end else if (low_found) begin
          pick_channel = low_index; // R05
          pick_level = css_pkg::LEVEL_LOW;
        end else begin
          pick_found = 1'b0;
        end
      end
      css_pkg::LEVEL_MIDDLE: begin
        if (middle_found) begin
          pick_channel = middle_index;
          pick_level = css_pkg::LEVEL_MIDDLE;
        end else if (high_found) begin
          pick_channel = high_index; // R07
          pick_level = css_pkg::LEVEL_HIGH;
        end else if (low_found) begin
          pick_channel = low_index; // R07
          pick_level = css_pkg::LEVEL_LOW;
        end else begin
          pick_found = 1'b0;
        end
      end
      default: begin
        // low slot; the table never yields the disabled code
        if (low_found) begin
          pick_channel = low_index;
          pick_level = css_pkg::LEVEL_LOW;
        end else if (high_found) begin
          pick_channel = high_index; // R06
          pick_level = css_pkg::LEVEL_HIGH;
        end else if (middle_found) begin
          pick_channel = middle_index; // R07
          pick_level = css_pkg::LEVEL_MIDDLE;
        end else begin
          pick_found = 1'b0;
        end
      end
    endcase
  end // R09

  assign pick_onehot = {{(CHANNELS-1){1'b0}}, 1'b1} << pick_channel;

  always_comb begin
    unique case (pick_level)
      css_pkg::LEVEL_HIGH: begin
        pick_level_mask = high_mask;
        pick_level_eligible = high_eligible;
      end
      css_pkg::LEVEL_MIDDLE: begin
        pick_level_mask = middle_mask;
        pick_level_eligible = middle_eligible;
      end
      default: begin
        pick_level_mask = low_mask;
        pick_level_eligible = low_eligible;
      end
    endcase
  end

  assign decide = (state == css_pkg::CSS_TRANSITION)
    && (trans_count == css_pkg::TRANSITION_CYCLES - 4'h1) && pick_found;
  // the level just served starts a new round only when nobody there is left waiting
  assign group_clear = decide && ((pick_level_eligible & ~pick_onehot) == '0); // R16 R17

  // flags: requests from enabled channels always win over the grant's clear
  always_comb begin
    next_request_flag = service_request_flag;
    next_granted_flag = service_granted_flag;
    if (decide) begin
      next_request_flag = service_request_flag & ~pick_onehot; // R14
      if (group_clear) begin
        next_granted_flag = service_granted_flag & ~pick_level_mask; // R15
      end else begin
        next_granted_flag = service_granted_flag | pick_onehot; // R14
      end
    end
    next_request_flag = next_request_flag | (chan_request & enabled_mask); // R14
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      service_request_flag <= '0;
      service_granted_flag <= '0;
    end else begin
      service_request_flag <= next_request_flag; // R13
      service_granted_flag <= next_granted_flag; // R13
    end
  end

  // slot state machine
  always_comb begin
    next_state = state;
    next_trans_count = trans_count;
    next_grant_channel = grant_channel;
    next_grant_level = grant_level;
    slot.advance = 1'b0;
    slot.restart = 1'b0;
    unique case (state)
      css_pkg::CSS_IDLE: begin
        if (any_eligible) begin
          next_state = css_pkg::CSS_TRANSITION;
          next_trans_count = 4'h0;
        end
      end
      css_pkg::CSS_TRANSITION: begin
        next_trans_count = trans_count + 4'h1; // R10
        if (trans_count == css_pkg::TRANSITION_CYCLES - 4'h1) begin
          if (pick_found) begin
            next_state = css_pkg::CSS_GRANT;
            next_grant_channel = pick_channel;
            next_grant_level = pick_level;
            slot.advance = 1'b1; // R02
          end else begin
            next_state = css_pkg::CSS_IDLE;
            slot.restart = 1'b1; // R08
          end
        end
      end
      css_pkg::CSS_GRANT: begin
        next_state = css_pkg::CSS_EXECUTE; // R01
      end
      css_pkg::CSS_EXECUTE: begin
        // the slot stretches for as long as the thread runs
        if (thread_done) begin
          next_state = css_pkg::CSS_TRANSITION; // R01 R20
          next_trans_count = 4'h0;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= css_pkg::CSS_IDLE;
      trans_count <= 4'h0;
      grant_channel <= '0;
      grant_level <= css_pkg::LEVEL_DISABLED;
    end else begin
      state <= next_state;
      trans_count <= next_trans_count;
      grant_channel <= next_grant_channel;
      grant_level <= next_grant_level;
    end
  end

  assign grant_valid = (state == css_pkg::CSS_GRANT); // R01
  assign engine_busy = (state == css_pkg::CSS_GRANT) || (state == css_pkg::CSS_EXECUTE);
  assign scheduler_idle = (state == css_pkg::CSS_IDLE); // R08
  assign slot_index = slot.slot_index;

endmodule : css_scheduler

// *** verification/css_scheduler_chk.sv ***
// concurrent checks on the scheduler ports
`timescale 1ns/1ps
module css_scheduler_chk #(
  parameter int CHANNELS = 32,
  parameter int INDEX_WIDTH = 5
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [CHANNELS-1:0] chan_request,
  input wire logic [2*CHANNELS-1:0] chan_priority,
  input wire logic thread_done,
  input wire logic grant_valid,
  input wire logic [INDEX_WIDTH-1:0] grant_channel,
  input wire logic [1:0] grant_level,
  input wire logic engine_busy,
  input wire logic scheduler_idle,
  input wire logic [2:0] slot_index,
  input wire logic [CHANNELS-1:0] service_request_flag,
  input wire logic [CHANNELS-1:0] service_granted_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [CHANNELS-1:0] req_d;
  logic [CHANNELS-1:0] gfl_d;
  logic [CHANNELS-1:0] lvl_mask;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_d <= '0;
      gfl_d <= '0;
    end else begin
      req_d <= chan_request;
      gfl_d <= service_granted_flag;
    end
  end
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      lvl_mask[i] = (chan_priority[2*i+:2] == grant_level);
    end
  end
  chk_grant_pulse: assert property (grant_valid |-> engine_busy ##1 !grant_valid)
    else $error("grant pulse longer than one cycle or engine not busy");
  chk_idle_quiet: assert property (scheduler_idle |-> !grant_valid && !engine_busy)
    else $error("grant while idle");
  chk_transition_len: assert property ((thread_done && engine_busy && !grant_valid) |=>
    (!grant_valid)[*6] ##1 (grant_valid || scheduler_idle || $past(scheduler_idle)))
    else $error("slot transition length wrong");
  chk_slot_advance: assert property (grant_valid |-> slot_index ==
    (($past(slot_index) == 3'h6) ? 3'h0 : $past(slot_index) + 3'h1))
    else $error("slot index did not advance");
  chk_idle_slot: assert property ($rose(scheduler_idle) |-> slot_index == 3'h0)
    else $error("idle without slot reset");
  chk_level_match: assert property (grant_valid |->
    grant_level != 2'h0 && grant_level == chan_priority[2*grant_channel+:2])
    else $error("grant level mismatch");
  chk_req_clear: assert property ((grant_valid && !req_d[grant_channel]) |->
    !service_request_flag[grant_channel])
    else $error("request flag not cleared on grant");
  chk_group_clear: assert property ((|(gfl_d & ~service_granted_flag)) |->
    (service_granted_flag & lvl_mask) == '0)
    else $error("granted flags cleared singly");
  cover property (grant_valid && grant_level == 2'h1);
  cover property ($rose(scheduler_idle));
  cover property (|(gfl_d & ~service_granted_flag));
endmodule : css_scheduler_chk

bind css_scheduler css_scheduler_chk #(.CHANNELS(CHANNELS), .INDEX_WIDTH(INDEX_WIDTH))
  u_css_scheduler_chk (.sys_clk(sys_clk), .reset_n(reset_n), .chan_request(chan_request),
  .chan_priority(chan_priority), .thread_done(thread_done), .grant_valid(grant_valid),
  .grant_channel(grant_channel), .grant_level(grant_level), .engine_busy(engine_busy),
  .scheduler_idle(scheduler_idle), .slot_index(slot_index),
  .service_request_flag(service_request_flag), .service_granted_flag(service_granted_flag));

// *** verification/css_engine_model.sv ***
// execution engine model: runs one thread per grant for a set time
`timescale 1ns/1ps
module css_engine_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic grant_valid,
  input wire logic [3:0] delay,
  output logic thread_done
);
  logic run;
  logic [3:0] cnt;
  // one grant at a time, one end pulse per grant, never before the cycle after the grant
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      run <= 1'b0;
      cnt <= 4'h0;
      thread_done <= 1'b0;
    end else begin
      thread_done <= 1'b0;
      if (grant_valid) begin
        run <= 1'b1;
        cnt <= delay;
      end else if (run) begin
        if (cnt == 4'h0) begin
          thread_done <= 1'b1;
          run <= 1'b0;
        end else begin
          cnt <= cnt - 4'h1;
        end
      end
    end
  end
endmodule : css_engine_model

// *** verification/tb_top.sv ***
// self-checking bench for the channel service scheduler
`timescale 1ns/1ps
module tb_top;
  logic sys_clk;
  logic reset_n;
  logic [31:0] chan_request;
  logic [63:0] chan_priority;
  logic thread_done;
  logic grant_valid;
  logic [4:0] grant_channel;
  logic [1:0] grant_level;
  logic engine_busy;
  logic scheduler_idle;
  logic [2:0] slot_index;
  logic [31:0] service_request_flag;
  logic [31:0] service_granted_flag;
  logic [3:0] delay;
  int miscompares = 0;
  int n_checks = 0;
  // slot levels high, middle, high, low, high, middle, high; slot 0 in low bits
  localparam logic [13:0] SEQ = 14'h3B7B;

  css_scheduler u_css_scheduler (.sys_clk(sys_clk), .reset_n(reset_n),
    .chan_request(chan_request), .chan_priority(chan_priority), .thread_done(thread_done),
    .grant_valid(grant_valid), .grant_channel(grant_channel), .grant_level(grant_level),
    .engine_busy(engine_busy), .scheduler_idle(scheduler_idle), .slot_index(slot_index),
    .service_request_flag(service_request_flag),
    .service_granted_flag(service_granted_flag));
  css_engine_model u_css_engine_model (.sys_clk(sys_clk), .reset_n(reset_n),
    .grant_valid(grant_valid), .delay(delay), .thread_done(thread_done));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  // bounded wait for the next grant pulse, sampled at a falling edge
  task automatic next_grant();
    int i;
    i = 0;
    do begin
      @(negedge sys_clk);
      i++;
    end while (grant_valid !== 1'b1 && i < 400);
    if (grant_valid !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end
  endtask : next_grant

  // drop requests and let pending flags drain
  task automatic wait_idle();
    int i;
    chan_request = '0;
    for (i = 0; i < 1000; i++) begin
      @(negedge sys_clk);
      if (scheduler_idle === 1'b1 && service_request_flag === '0) break;
    end
    if (i == 1000) begin
      miscompares++;
      report_and_stop();
    end
    check(slot_index, 0);
  endtask : wait_idle

  // expected granted level for a slot level and the set of requesting levels
  function automatic logic [1:0] pick(input logic [1:0] s, input logic [2:0] av);
    logic [5:0] p;
    p = (s == 2'h3) ? 6'h39 : (s == 2'h2) ? 6'h2D : 6'h1E;
    for (int i = 2; i >= 0; i--) begin
      if (av[p[2*i+:2]-2'h1]) return p[2*i+:2];
    end
    return 2'h0;
  endfunction : pick

  // channels 0, 5, 9 high and requesting without pause; channel 7 disabled
  task automatic sc_number_order();
    logic [4:0] ch [3];
    logic [31:0] gf [3];
    ch = '{5'h00, 5'h05, 5'h09};
    gf = '{32'h1, 32'h21, 32'h0};
    chan_priority = 64'h00000000000C0C03;
    chan_request = 32'h000002A1;
    delay = 4'h0;
    for (int k = 0; k < 6; k++) begin
      next_grant();
      check(grant_channel, ch[k%3]);
      check(service_granted_flag, gf[k%3]);
      check(service_request_flag[7], 0);
    end
    wait_idle();
  endtask : sc_number_order

  // one channel per level; every mix of requesting levels, past one full sequence
  task automatic sc_slot_levels();
    logic [1:0] lv;
    chan_priority = 64'h000000000000006C;
    for (int av = 1; av < 8; av++) begin
      delay = av[0] ? 4'h0 : 4'h6;
      chan_request = {28'h0, av[0], av[1], av[2], 1'b0};
      for (int k = 0; k < 9; k++) begin
        next_grant();
        lv = pick(SEQ[2*(k%7)+:2], av[2:0]);
        check(grant_level, lv);
        check(grant_channel, 3'h4 - lv);
      end
      wait_idle();
    end
  endtask : sc_slot_levels

  initial begin
    reset_n = 1'b0;
    chan_request = '0;
    chan_priority = '0;
    delay = 4'h0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    check({grant_valid, engine_busy, scheduler_idle, slot_index}, 6'h08);
    check(service_granted_flag | service_request_flag, 0);
    sc_number_order();
    sc_slot_levels();
    report_and_stop();
  end
endmodule : tb_top
